// ---- hdl/em_mac_top.sv ----
`timescale 1ns/1ns
module em_mac_top (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // configuration and test
  input wire logic mode_four_lane_in,
  input wire logic test_gen_in,
  input wire logic test_chk_in,
  // receive lanes
  input wire logic [em_pkg::LANES-1:0] rx_lane_recovered_clock_in,
  input wire logic [em_pkg::LANES-1:0] rx_lane_reset_in,
  input wire logic [em_pkg::WIDE_LANES-1:0][em_pkg::MAIN_W-1:0] rx_lane_main_group_in,
  input wire logic [em_pkg::WIDE_LANES-1:0][em_pkg::UPPER_W-1:0] rx_lane_upper_group_in,
  input wire logic [em_pkg::NARROW_LANES-1:0][em_pkg::NARROW_W-1:0] rx_lane_narrow_in,
  // transmit lanes
  output logic [em_pkg::WIDE_LANES-1:0][em_pkg::MAIN_W-1:0] tx_lane_main_group_out,
  output logic [em_pkg::WIDE_LANES-1:0][em_pkg::UPPER_W-1:0] tx_lane_upper_group_out,
  output logic [em_pkg::NARROW_LANES-1:0][em_pkg::NARROW_W-1:0] tx_lane_narrow_out,
  // receive user stream
  output logic rx_valid_out,
  output em_pkg::em_beat_s rx_beat_out,
  // transmit user stream
  input wire logic tx_valid_in,
  input wire em_pkg::em_beat_s tx_beat_in,
  output logic tx_ready_out,
  output logic tx_underflow_out,
  // pause
  output logic rx_pause_valid_out,
  output logic rx_pause_prio_out,
  output em_pkg::em_pause_s rx_pause_out,
  input wire logic tx_pause_req_in,
  input wire logic tx_pause_prio_in,
  input wire em_pkg::em_pause_s tx_pause_in,
  output logic tx_pause_busy_out,
  // statistics
  output em_pkg::em_rx_stat_s rx_stat_out,
  output em_pkg::em_tx_stat_s tx_stat_out,
  output logic test_err_out
);
  // ----------------------------------------------------------------
  // receive lane capture
  // ----------------------------------------------------------------
  logic [em_pkg::LANES-1:0] new_w;
  logic [em_pkg::LANES-1:0] live_w;
  logic [em_pkg::LANES-1:0][em_pkg::WIDE_W-1:0] lane_w;
  logic [em_pkg::LANES-1:0] active;
  logic take_word;

  assign active = mode_four_lane_in ? em_pkg::ACTIVE_FOUR : em_pkg::ACTIVE_TEN;
  // active lanes still in reset hold off assembly
  assign take_word = &(new_w | ~active) & ~|(~live_w & active);

  // ten lane buses, narrow ones zero-extended
  for (genvar i = 0; i < em_pkg::LANES; i++) begin : g_rx_lane
    logic [em_pkg::WIDE_W-1:0] raw;
    logic ck1_q, ck2_q, ck3_q, rs1_q, rs2_q, new_q;
    logic [em_pkg::WIDE_W-1:0] d1_q, d2_q, lane_q;
    if (i < em_pkg::WIDE_LANES) begin : g_wide
      assign raw = {rx_lane_upper_group_in[i], rx_lane_main_group_in[i]};
    end else begin : g_narrow
      // lanes 4 to 9 carry 32 bits
      assign raw = {48'h0000_0000_0000, rx_lane_narrow_in[i - em_pkg::WIDE_LANES]};
    end
    // lane reset brought through two flops
    always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
        ck1_q <= 1'b0;
        ck2_q <= 1'b0;
        ck3_q <= 1'b0;
        rs1_q <= 1'b1;
        rs2_q <= 1'b1;
        d1_q <= '0;
        d2_q <= '0;
      end else begin
        ck1_q <= rx_lane_recovered_clock_in[i];
        ck2_q <= ck1_q;
        ck3_q <= ck2_q;
        rs1_q <= rx_lane_reset_in[i];
        rs2_q <= rs1_q;
        d1_q <= raw;
        d2_q <= d1_q;
      end
    end
    // capture on this lane's own clock rise
    always_ff @(posedge clk_in) begin
      if (sys_rst_in || rs2_q) begin
        lane_q <= '0;
        new_q <= 1'b0;
      end else begin
        if (ck2_q && !ck3_q) begin
          lane_q <= d2_q;
        end
        new_q <= (new_q & ~take_word) | (ck2_q & ~ck3_q);
      end
    end
    assign new_w[i] = new_q;
    assign live_w[i] = ~rs2_q;
    assign lane_w[i] = lane_q;
  end

  logic [em_pkg::WORD_W-1:0] rx_word;
  always_comb begin
    rx_word = '0;
    if (mode_four_lane_in) begin
      for (int l = 0; l < em_pkg::WIDE_LANES; l++) begin
        rx_word[l*em_pkg::WIDE_W +: em_pkg::WIDE_W] = lane_w[l];
      end
    end else begin
      // only low 32 bits of each lane
      for (int l = 0; l < em_pkg::LANES; l++) begin
        rx_word[l*em_pkg::NARROW_W +: em_pkg::NARROW_W] = lane_w[l][em_pkg::NARROW_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // receive beat stage and test checker
  // ----------------------------------------------------------------
  logic [63:0] chk_out;
  em_scr #(.DESCR(1'b1)) u_chk (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .step_in(take_word & test_chk_in),
    .data_in(rx_word[63:0]),
    .data_out(chk_out)
  );

  // one register stage between lanes and user
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rx_valid_out <= 1'b0;
      rx_beat_out <= '0;
      test_err_out <= 1'b0;
    end else begin
      rx_valid_out <= take_word & rx_word[em_pkg::CTRL_VALID] & ~test_chk_in;
      // descrambled idle must be all zero
      test_err_out <= take_word & test_chk_in & (|chk_out);
      if (take_word) begin
        rx_beat_out <= '{data: rx_word[63:0], sop: rx_word[em_pkg::CTRL_SOP],
          eop: rx_word[em_pkg::CTRL_EOP], err: rx_word[em_pkg::CTRL_ERR],
          mty: rx_word[em_pkg::CTRL_MTY_LSB +: 3]};
      end
    end
  end

  // ----------------------------------------------------------------
  // receive frame checks and pause parsing
  // ----------------------------------------------------------------
  logic [2:0] idx_q;
  logic [13:0] bytes_q;
  logic [15:0] lenfld_q;
  logic pause_q, prio_q;
  logic [2:0][63:0] pay_q;
  logic [2:0] idx;
  logic [3:0] nbytes;
  logic [13:0] total;
  logic [15:0] lenfld;
  logic is_pause, is_prio, len_err, bad;

  always_comb begin
    idx = rx_beat_out.sop ? 3'h0 : idx_q;
    nbytes = rx_beat_out.eop ? em_pkg::BEAT_BYTES - {1'b0, rx_beat_out.mty} : em_pkg::BEAT_BYTES;
    total = (rx_beat_out.sop ? 14'h0000 : bytes_q) + {10'h000, nbytes};
    lenfld = (idx == 3'h1) ? rx_beat_out.data[31:16] : lenfld_q;
    is_pause = (idx == 3'h1) ? (rx_beat_out.data[31:16] == em_pkg::ETYPE_PAUSE &&
      (rx_beat_out.data[15:0] == em_pkg::OPC_GLOBAL ||
       rx_beat_out.data[15:0] == em_pkg::OPC_PRIO)) : (pause_q && idx != 3'h0);
    is_prio = (idx == 3'h1) ? (rx_beat_out.data[15:0] == em_pkg::OPC_PRIO) : prio_q;
    // bad length field, undersize or oversize
    len_err = (total < em_pkg::MIN_LEN) || (total > em_pkg::MAX_LEN) ||
      (idx != 3'h0 && lenfld <= em_pkg::MAX_LEN_FIELD &&
       lenfld[13:0] != total - em_pkg::LEN_OVERHEAD);
    // any fcs or length error makes it bad
    bad = rx_beat_out.err | len_err;
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      idx_q <= 3'h0;
      bytes_q <= 14'h0000;
      lenfld_q <= 16'hFFFF;
      pause_q <= 1'b0;
      prio_q <= 1'b0;
    end else if (rx_valid_out) begin
      idx_q <= (idx == 3'h7) ? idx : idx + 3'h1;
      bytes_q <= total;
      lenfld_q <= lenfld;
      pause_q <= is_pause;
      prio_q <= is_prio;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rx_valid_out && idx >= 3'h2 && idx <= 3'h4) begin
      pay_q[idx - 3'h2] <= rx_beat_out.data;
    end
  end

  logic [191:0] pay_flat;
  assign pay_flat = {pay_q[0], pay_q[1], pay_q[2]};

  // quanta published when a clean pause frame ends
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rx_pause_valid_out <= 1'b0;
      rx_pause_prio_out <= 1'b0;
      rx_pause_out <= '0;
    end else begin
      rx_pause_valid_out <= rx_valid_out & rx_beat_out.eop & is_pause & ~bad;
      if (rx_valid_out && rx_beat_out.eop && is_pause && !bad) begin
        rx_pause_prio_out <= is_prio;
        rx_pause_out <= '0;
        if (is_prio) begin
          rx_pause_out.enable <= pay_flat[183:176];
          for (int k = 0; k < em_pkg::PRIO_CLASSES; k++) begin
            rx_pause_out.quanta[k] <= pay_flat[175 - 16*k -: 16];
          end
        end else begin
          rx_pause_out.quanta[0] <= pay_flat[191:176];
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rx_stat_out <= '0;
    end else begin
      rx_stat_out <= '0;
      if (rx_valid_out) begin
        rx_stat_out.total_bytes <= nbytes;
        if (rx_beat_out.eop) begin
          rx_stat_out.total_pkts <= 1'b1;
          rx_stat_out.good_pkts <= ~bad;
          rx_stat_out.bad_pkts <= bad;
          rx_stat_out.bad_fcs <= rx_beat_out.err;
          rx_stat_out.len_err <= len_err;
          rx_stat_out.pause_pkts <= is_pause & ~bad;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // transmit path
  // ----------------------------------------------------------------
  logic buf_valid, pop, start;
  em_pkg::em_beat_s buf_beat;
  logic pend_q, inj_q, in_pkt_q, unf_q, req_prio_q;
  logic [2:0] inj_cnt_q;
  em_pkg::em_pause_s req_q;

  // user beats taken on clk_in through the buffer
  em_skid #(.W($bits(em_pkg::em_beat_s))) u_skid (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .in_valid_in(tx_valid_in),
    .in_data_in(tx_beat_in),
    .in_ready_out(tx_ready_out),
    .out_valid_out(buf_valid),
    .out_data_out(buf_beat),
    .out_ready_in(pop)
  );

  // pause waits for a packet boundary so user frames are never split
  assign start = pend_q & ~inj_q & ~in_pkt_q & ~test_gen_in;
  // drain stalls only for injection or test
  assign pop = buf_valid & ~inj_q & ~start & ~test_gen_in;
  assign tx_pause_busy_out = pend_q | inj_q;

  // request latched, set wins over start
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pend_q <= 1'b0;
      inj_q <= 1'b0;
      inj_cnt_q <= 3'h0;
      req_q <= '0;
      req_prio_q <= 1'b0;
    end else begin
      pend_q <= tx_pause_req_in | (pend_q & ~start);
      if (tx_pause_req_in && !inj_q) begin
        req_q <= tx_pause_in;
        req_prio_q <= tx_pause_prio_in;
      end
      if (start) begin
        inj_q <= 1'b1;
        inj_cnt_q <= 3'h0;
      end else if (inj_q) begin
        inj_q <= (inj_cnt_q != em_pkg::PAUSE_LAST);
        inj_cnt_q <= inj_cnt_q + 3'h1;
      end
    end
  end

  logic [191:0] inj_pay;
  em_pkg::em_beat_s tx_beat;
  logic tx_live;
  logic [47:0] src_mac;
  assign src_mac = 48'h0200_0000_0001;

  always_comb begin
    inj_pay = req_prio_q ? {8'h00, req_q.enable, req_q.quanta, 48'h0000_0000_0000}
                         : {req_q.quanta[0], 176'h0};
    tx_beat = '0;
    tx_live = 1'b0;
    if (inj_q) begin
      tx_live = 1'b1;
      case (inj_cnt_q)
        3'h0: tx_beat.data = {em_pkg::PAUSE_DA, src_mac[47:32]};
        3'h1: tx_beat.data = {src_mac[31:0], em_pkg::ETYPE_PAUSE,
                              req_prio_q ? em_pkg::OPC_PRIO : em_pkg::OPC_GLOBAL};
        3'h2: tx_beat.data = inj_pay[191:128];
        3'h3: tx_beat.data = inj_pay[127:64];
        3'h4: tx_beat.data = inj_pay[63:0];
        default: tx_beat.data = 64'h0000_0000_0000_0000;
      endcase
      tx_beat.sop = (inj_cnt_q == 3'h0);
      tx_beat.eop = (inj_cnt_q == em_pkg::PAUSE_LAST);
    end else if (pop) begin
      tx_live = 1'b1;
      tx_beat = buf_beat;
      tx_beat.err = buf_beat.err | unf_q;
    end
  end

  // underflow: inside a packet with nothing to send
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      in_pkt_q <= 1'b0;
      unf_q <= 1'b0;
      tx_underflow_out <= 1'b0;
    end else begin
      tx_underflow_out <= in_pkt_q & ~pop & ~test_gen_in;
      if (pop) begin
        in_pkt_q <= buf_beat.eop ? 1'b0 : (buf_beat.sop | in_pkt_q);
        unf_q <= buf_beat.eop ? 1'b0 : unf_q;
      end else if (in_pkt_q && !test_gen_in) begin
        unf_q <= 1'b1;
      end
    end
  end

  // good only with neither fcs nor other error
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      tx_stat_out <= '0;
    end else begin
      tx_stat_out <= '0;
      if (pop) begin
        tx_stat_out.total_bytes <= buf_beat.eop ?
          em_pkg::BEAT_BYTES - {1'b0, buf_beat.mty} : em_pkg::BEAT_BYTES;
        tx_stat_out.total_pkts <= buf_beat.eop;
        tx_stat_out.good_pkts <= buf_beat.eop & ~(buf_beat.err | unf_q);
        tx_stat_out.bad_pkts <= buf_beat.eop & (buf_beat.err | unf_q);
      end
    end
  end

  logic [63:0] gen_out;
  // generator scrambles an all-zero idle stream
  em_scr #(.DESCR(1'b0)) u_gen (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .step_in(test_gen_in),
    .data_in(64'h0000_0000_0000_0000),
    .data_out(gen_out)
  );

  logic [em_pkg::WORD_W-1:0] tx_word;
  always_comb begin
    tx_word = '0;
    if (test_gen_in) begin
      tx_word[63:0] = gen_out;
    end else begin
      tx_word[71:0] = {tx_live, tx_beat.sop, tx_beat.eop, tx_beat.err, 1'b0,
                       tx_beat.mty, tx_beat.data};
    end
  end

  // lane split per mode, registered outputs
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      tx_lane_main_group_out <= '0;
      tx_lane_upper_group_out <= '0;
      tx_lane_narrow_out <= '0;
    end else if (mode_four_lane_in) begin
      for (int l = 0; l < em_pkg::WIDE_LANES; l++) begin
        // low 64 main, high 16 upper
        tx_lane_main_group_out[l] <= tx_word[l*em_pkg::WIDE_W +: em_pkg::MAIN_W];
        tx_lane_upper_group_out[l] <= tx_word[l*em_pkg::WIDE_W + em_pkg::MAIN_W +: 16];
      end
      tx_lane_narrow_out <= '0;
    end else begin
      // ten-lane mode drives low 32 bits only
      for (int l = 0; l < em_pkg::WIDE_LANES; l++) begin
        tx_lane_main_group_out[l] <= {32'h0000_0000, tx_word[l*em_pkg::NARROW_W +: 32]};
        tx_lane_upper_group_out[l] <= 16'h0000;
      end
      // lanes 4 to 9 are 32 bits
      for (int l = em_pkg::WIDE_LANES; l < em_pkg::LANES; l++) begin
        tx_lane_narrow_out[l - em_pkg::WIDE_LANES] <= tx_word[l*em_pkg::NARROW_W +: 32];
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  chk_rx_cut_through: assert property (
    take_word && rx_word[em_pkg::CTRL_VALID] && !test_chk_in |=> rx_valid_out)
    else $error("rx beat not forwarded next cycle");
  chk_tx_pop_lane: assert property (
    pop && !mode_four_lane_in ##1 !mode_four_lane_in |-> tx_lane_main_group_out[2][7])
    else $error("popped beat missing valid on lanes");
  chk_rx_good_bad: assert property (
    rx_stat_out.total_pkts |-> (rx_stat_out.good_pkts != rx_stat_out.bad_pkts))
    else $error("rx packet both good and bad");
  chk_rx_len_bad: assert property (
    rx_stat_out.len_err || rx_stat_out.bad_fcs |-> rx_stat_out.bad_pkts)
    else $error("length or fcs error not counted bad");
  chk_tx_good_bad: assert property (
    tx_stat_out.good_pkts |-> tx_stat_out.total_pkts && !tx_stat_out.bad_pkts)
    else $error("tx good packet inconsistent");
  chk_pause_stat: assert property (
    rx_pause_valid_out |-> $past(rx_valid_out) && rx_stat_out.pause_pkts)
    else $error("pause quanta without counted pause frame");
  chk_inject_len: assert property (
    start |=> inj_q [*8])
    else $error("pause injection shorter than eight beats");
  chk_ten_upper: assert property (
    !$past(mode_four_lane_in) |-> tx_lane_upper_group_out == '0)
    else $error("upper group driven in ten-lane mode");
  chk_test_err: assert property (
    test_err_out |-> $past(test_chk_in) && !rx_valid_out)
    else $error("test error outside checker mode");

  cov_rx_pause: cover property (rx_pause_valid_out && rx_pause_prio_out);
  cov_tx_inject: cover property (start ##8 !inj_q);
  cov_tx_underflow: cover property (tx_underflow_out);
  cov_tx_stall: cover property (tx_valid_in && !tx_ready_out);
endmodule

// ---- hdl/em_pkg.sv ----
package em_pkg;
  // ----------------------------------------------------------------
  // lane geometry
  // ----------------------------------------------------------------
  localparam int LANES = 10;
  localparam int WIDE_LANES = 4;
  localparam int NARROW_LANES = 6;
  localparam int MAIN_W = 64;
  localparam int UPPER_W = 16;
  localparam int NARROW_W = 32;
  localparam int WIDE_W = 80;
  localparam int WORD_W = 320;
  localparam logic [9:0] ACTIVE_FOUR = 10'h00F;
  localparam logic [9:0] ACTIVE_TEN = 10'h3FF;
  // ----------------------------------------------------------------
  // beat framing inside a lane word
  // ----------------------------------------------------------------
  localparam int BEAT_W = 64;
  localparam int CTRL_VALID = 71;
  localparam int CTRL_SOP = 70;
  localparam int CTRL_EOP = 69;
  localparam int CTRL_ERR = 68;
  localparam int CTRL_MTY_LSB = 64;
  localparam logic [3:0] BEAT_BYTES = 4'h8;
  // ----------------------------------------------------------------
  // frame checks
  // ----------------------------------------------------------------
  localparam logic [13:0] MIN_LEN = 14'h0040;
  localparam logic [13:0] MAX_LEN = 14'h05EE;
  localparam logic [13:0] LEN_OVERHEAD = 14'h0012;
  localparam logic [15:0] MAX_LEN_FIELD = 16'h05DC;
  // ----------------------------------------------------------------
  // pause frames
  // ----------------------------------------------------------------
  localparam logic [15:0] ETYPE_PAUSE = 16'h8808;
  localparam logic [15:0] OPC_GLOBAL = 16'h0001;
  localparam logic [15:0] OPC_PRIO = 16'h0101;
  localparam logic [47:0] PAUSE_DA = 48'h0180_C200_0001;
  localparam logic [2:0] PAUSE_LAST = 3'h7;
  localparam int PRIO_CLASSES = 8;
  // ----------------------------------------------------------------
  // test pattern scrambler, x^58 + x^39 + 1
  // ----------------------------------------------------------------
  localparam int SCR_LEN = 58;
  localparam int SCR_TAP = 39;
  localparam logic [57:0] SCR_SEED = 58'h3FF_FFFF_FFFF_FFFF;

  typedef struct packed {
    logic [63:0] data;
    logic sop;
    logic eop;
    logic err;
    logic [2:0] mty;
  } em_beat_s;

  typedef struct packed {
    logic [7:0] enable;
    logic [PRIO_CLASSES-1:0][15:0] quanta;
  } em_pause_s;

  typedef struct packed {
    logic total_pkts;
    logic good_pkts;
    logic bad_pkts;
    logic bad_fcs;
    logic len_err;
    logic pause_pkts;
    logic [3:0] total_bytes;
  } em_rx_stat_s;

  typedef struct packed {
    logic total_pkts;
    logic good_pkts;
    logic bad_pkts;
    logic [3:0] total_bytes;
  } em_tx_stat_s;
endpackage

// ---- hdl/em_scr.sv ----
`timescale 1ns/1ns
// self-synchronising 64-bit scrambler or descrambler
module em_scr #(
  parameter bit DESCR = 1'b0
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // data
  input wire logic step_in,
  input wire logic [63:0] data_in,
  output logic [63:0] data_out
);
  logic [57:0] st_q;
  logic [121:0] ext;

  // ext[57:0] is history, ext[58+i] the line bit of position i
  always_comb begin
    ext = {64'h0000_0000_0000_0000, st_q};
    data_out = 64'h0000_0000_0000_0000;
    for (int i = 0; i < 64; i++) begin
      data_out[i] = data_in[i] ^ ext[i + em_pkg::SCR_LEN - em_pkg::SCR_TAP] ^ ext[i];
      ext[em_pkg::SCR_LEN + i] = DESCR ? data_in[i] : data_out[i];
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_q <= em_pkg::SCR_SEED;
    end else if (step_in) begin
      st_q <= ext[121:64];
    end
  end
endmodule

// ---- hdl/em_skid.sv ----
`timescale 1ns/1ns
// two-entry buffer; ready depends only on fill so the source sees no loop
module em_skid #(
  parameter int W = 70
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // fill side
  input wire logic in_valid_in,
  input wire logic [W-1:0] in_data_in,
  output logic in_ready_out,
  // drain side
  output logic out_valid_out,
  output logic [W-1:0] out_data_out,
  input wire logic out_ready_in
);
  logic [W-1:0] mem_q [2];
  logic wr_q;
  logic rd_q;
  logic [1:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready_out = (cnt_q != 2'h2);
  assign out_valid_out = (cnt_q != 2'h0);
  assign out_data_out = mem_q[rd_q];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_q[wr_q] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      wr_q <= wr_q ^ push;
      rd_q <= rd_q ^ pop;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// ---- tb/em_lane_model.sv ----
`timescale 1ns/1ns
// clocks stand still low between words
module em_lane_model (
  // clock
  input wire logic clk_in,
  // lanes
  output logic [9:0] rck_out,
  output logic [3:0][63:0] main_out,
  output logic [3:0][15:0] upper_out,
  output logic [5:0][31:0] narrow_out
);
  initial begin
    rck_out = '0;
    main_out = '0;
    upper_out = '0;
    narrow_out = '0;
  end
  // ----
  // word send
  // ----
  // data steady over rise
  task automatic send(input logic four, input logic [319:0] w);
    for (int l = 0; l < 10; l++) begin
      if (l < 4) begin
        main_out[l] = four ? w[80*l+:64] : {32'h5A5A_A5A5, w[32*l+:32]};
        upper_out[l] = four ? w[80*l+64+:16] : 16'hFFFF;
      end else begin
        narrow_out[l-4] = w[32*l+:32];
      end
    end
    @(posedge clk_in);
    #1 rck_out = '1;
    repeat (3) @(posedge clk_in);
    #1 rck_out = '0;
    // held time over: show inverse, not stale data
    main_out = ~main_out;
    upper_out = ~upper_out;
    narrow_out = ~narrow_out;
    repeat (2) @(posedge clk_in);
    // hand back off the edge so the caller never races the sampling flops
    #1;
  endtask
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic four = 1'b1;
  logic tx_valid = 1'b0;
  logic preq = 1'b0;
  logic tgen = 1'b0;
  logic pvalid, pprio;
  em_pkg::em_pause_s rpause;
  logic [31:0] acc_pkts = '0;
  logic [31:0] acc_bytes = '0;
  logic [9:0] lrst = '1;
  logic [9:0] rck;
  logic rx_valid, pbusy, tready;
  logic [3:0][63:0] rmain, tmain;
  logic [3:0][15:0] rup, tup;
  logic [5:0][31:0] rnar;
  em_pkg::em_beat_s rx_beat;
  em_pkg::em_beat_s tx_beat = '0;
  em_pkg::em_pause_s pause = '0;
  em_pkg::em_rx_stat_s rs;
  em_pkg::em_tx_stat_s ts;
  int miscompares = 0;
  int samples_checked = 0;
  int cyc = 0;
  em_lane_model em_lane_model_i (.clk_in, .rck_out(rck), .main_out(rmain),
    .upper_out(rup), .narrow_out(rnar));
  em_mac_top em_mac_top_i (.clk_in, .sys_rst_in, .mode_four_lane_in(four),
    .test_gen_in(tgen), .test_chk_in(1'b0), .rx_lane_recovered_clock_in(rck),
    .rx_lane_reset_in(lrst), .rx_lane_main_group_in(rmain),
    .rx_lane_upper_group_in(rup), .rx_lane_narrow_in(rnar),
    .tx_lane_main_group_out(tmain), .tx_lane_upper_group_out(tup),
    .tx_lane_narrow_out(), .rx_valid_out(rx_valid), .rx_beat_out(rx_beat),
    .tx_valid_in(tx_valid), .tx_beat_in(tx_beat), .tx_ready_out(tready),
    .tx_underflow_out(), .rx_pause_valid_out(pvalid), .rx_pause_prio_out(pprio),
    .rx_pause_out(rpause), .tx_pause_req_in(preq), .tx_pause_prio_in(1'b0),
    .tx_pause_in(pause), .tx_pause_busy_out(pbusy), .rx_stat_out(rs),
    .tx_stat_out(ts), .test_err_out());
  // user side sums the per-cycle increments
  always @(posedge clk_in) begin
    if (!sys_rst_in) begin
      acc_pkts <= acc_pkts + 32'(rs.total_pkts);
      acc_bytes <= acc_bytes + 32'(rs.total_bytes);
    end
  end
  // stimulus moves just after the rising edge
  task automatic tick();
    @(posedge clk_in);
    #1;
  endtask
  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d bad %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // wait for the valid bit on lane 0
  task automatic wait_tx();
    for (int i = 0; i < 20 && tup[0][7] !== 1'b1; i++) tick();
  endtask
  task automatic test_tx();
    tx_beat = '{64'h1122_3344_5566_7788, 1'b1, 1'b1, 1'b0, 3'h0};
    tx_valid = 1'b1;
    chk(tready === 1'b1, "not ready"); // ready
    tick();
    tx_valid = 1'b0;
    wait_tx();
    chk(tmain[0] === tx_beat.data, "tx lane data"); // lane split
    chk(ts.good_pkts === 1'b1 && ts.bad_pkts === 1'b0, "tx stat"); // good
    $display("tx done");
  endtask
  task automatic test_pause();
    pause.quanta[0] = 16'h0010;
    preq = 1'b1;
    tick();
    preq = 1'b0;
    chk(pbusy === 1'b1, "not busy"); // pause req
    wait_tx();
    chk(tmain[0] === {em_pkg::PAUSE_DA, 16'h0200}, "pause da"); // inject
    tick();
    chk(tmain[0][31:0] === {em_pkg::ETYPE_PAUSE, em_pkg::OPC_GLOBAL}, "opc");
    $display("pause done");
  endtask
  // 8-byte frame: data routed by mode, counted as undersize
  task automatic test_rx(input logic m, input logic [63:0] d);
    four = m;
    tick();
    fork
      em_lane_model_i.send(m, {248'h0, 8'hE0, d});
    join_none
    for (int i = 0; i < 30 && rx_valid !== 1'b1; i++) tick();
    chk(rx_beat.data === d && rx_beat.eop === 1'b1, "rx data"); // mode
    tick();
    chk(rs.len_err === 1'b1 && rs.bad_pkts === 1'b1, "len err"); // short
    chk(rs.good_pkts === 1'b0 && rs.total_pkts === 1'b1, "rx stat"); // bad
    wait fork;
    $display("rx done");
  endtask
  // 64-byte global pause frame, quanta in first payload beat
  task automatic test_rx_pause();
    logic [63:0] d;
    for (int b = 0; b < 8; b++) begin
      d = (b == 1) ? {32'h0000_0000, em_pkg::ETYPE_PAUSE, em_pkg::OPC_GLOBAL} :
        (b == 2) ? 64'h0123_0000_0000_0000 : 64'h0000_0000_0000_0000;
      em_lane_model_i.send(1'b1, {248'h0, 1'b1, b == 0, b == 7, 5'h00, d});
    end
    for (int i = 0; i < 10 && pvalid !== 1'b1; i++) tick();
    chk(pvalid === 1'b1 && rpause.quanta[0] === 16'h0123 && pprio === 1'b0, "rx pause");
    chk(rs.pause_pkts === 1'b1 && rs.good_pkts === 1'b1, "pause stat");
    $display("rx pause done");
  endtask
  // generator: scrambled idle words, no framing bit
  task automatic test_gen();
    logic [63:0] w;
    tgen = 1'b1;
    repeat (2) tick();
    w = tmain[0];
    tick();
    chk(w !== 64'h0000_0000_0000_0000 && tmain[0] !== w && tup[0] === 16'h0000, "pattern");
    tgen = 1'b0;
    tick();
    $display("gen done");
  endtask
  initial forever #25 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      complete_run();
    end
  end
  initial begin
    repeat (3) tick();
    sys_rst_in = 1'b0;
    // lane resets held through start-up
    lrst = '0;
    repeat (4) tick();
    test_tx();
    test_pause();
    test_rx(1'b0, 64'hA1B2_C3D4_E5F6_0718);
    test_rx(1'b1, 64'h0F1E_2D3C_4B5A_6978);
    test_rx_pause();
    test_gen();
    chk(acc_pkts === 32'h0000_0003 && acc_bytes === 32'h0000_0050, "counters");
    complete_run();
  end
endmodule
